// ### hdl/low_power_mode_control.sv
// Stop and wait mode controller with watchdog wake timing, APB registers
`timescale 1ns/10ps
module low_power_mode_control
  import lpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [lpm_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [lpm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic wake_irq,
  output logic osc_en,
  output logic pll_run,
  output logic cpu_clk_en,
  output logic bus_interface_clock_en,
  output logic watchdog_fast_count_clock_en,
  output logic watchdog_slow_count_clock_en,
  output logic system_clock_signal_en,
  output logic divided_peripheral_clocks_en,
  output logic timer_event_only,
  output logic serial_ext_clock_only,
  output logic converter_run,
  output logic pin_hold,
  output logic wdt_irq
);
  import lpm_pkg::*;

  lpm_state_t state_q, state_d;
  logic [PRE_W-1:0] pre_q;
  logic freq_sel_q, stop_dis_q, ext_clk_q, stop_flag_q, wait_flag_q;
  wake_src_t wake_src_q;
  logic sys_stop_q, pll_en_q, sys_sel_q;
  logic [DATA_W-1:0] rdata_q;
  logic err_q, wr_acc, mapped, restart_wr, select_wr;
  logic stop_take, wait_take, timed_wake, slow_clk_off;
  logic run_tick, wake_tick, wdt_tick, wdt_load, wdt_expire;
  logic [WDT_W-1:0] wdt_count;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == REG_WDT) || (paddr == REG_MODE0) ||
                  (paddr == REG_MODE1) || (paddr == REG_CLK) ||
                  (paddr == REG_STAT);
  assign restart_wr = wr_acc && (paddr == REG_WDT) && pstrb[STRB_RESTART];
  assign select_wr = wr_acc && (paddr == REG_WDT) && pstrb[STRB_SELECT];

  // Read data captured in setup so it stands for the whole access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= DATA_ZERO;
      err_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      rdata_q <= DATA_ZERO;
      err_q <= !mapped;
      if (!pwrite)
      begin
        case (paddr)
          REG_WDT:
          begin
            rdata_q[BIT_FREQ_SEL] <= freq_sel_q;
            rdata_q[BIT_WAKE_SRC_HI:BIT_WAKE_SRC_LO] <= wake_src_q;
          end
          REG_MODE0:
          begin
            rdata_q[BIT_STOP_DIS] <= stop_dis_q;
            rdata_q[BIT_EXT_CLK] <= ext_clk_q;
          end
          REG_MODE1:
          begin
            rdata_q[BIT_STOP_FLAG] <= stop_flag_q;
            rdata_q[BIT_WAIT_FLAG] <= wait_flag_q;
            rdata_q[BIT_SYS_STOP] <= sys_stop_q;
          end
          REG_CLK:
          begin
            rdata_q[BIT_PLL_EN] <= pll_en_q;
            rdata_q[BIT_SYS_SEL] <= sys_sel_q;
          end
          REG_STAT:
          begin
            rdata_q[WDT_W-1:0] <= wdt_count;
            rdata_q[BIT_STATE_LO+1:BIT_STATE_LO] <= state_q;
          end
          default:
            rdata_q <= DATA_ZERO;
        endcase
      end
    end
  end

  // Select byte rides along with a two-lane restart write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_sel_q <= 1'b0;
      wake_src_q <= SRC_DIV32;
    end
    else if (select_wr)
    begin
      freq_sel_q <= pwdata[BIT_FREQ_SEL];
      wake_src_q <= wake_src_t'(pwdata[BIT_WAKE_SRC_HI:BIT_WAKE_SRC_LO]);
    end
  end

  // Write-unlock sequence is not modelled: plain writes update these
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_dis_q <= 1'b0;
      ext_clk_q <= 1'b0;
      sys_stop_q <= 1'b0;
      pll_en_q <= 1'b0;
      sys_sel_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == REG_MODE0)
      begin
        stop_dis_q <= pwdata[BIT_STOP_DIS];
        ext_clk_q <= pwdata[BIT_EXT_CLK];
      end
      if (paddr == REG_MODE1)
        sys_stop_q <= pwdata[BIT_SYS_STOP];
      if (paddr == REG_CLK)
      begin
        pll_en_q <= pwdata[BIT_PLL_EN];
        sys_sel_q <= pwdata[BIT_SYS_SEL];
      end
    end
  end

  // Entry flags: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_flag_q <= 1'b0;
      wait_flag_q <= 1'b0;
    end
    else
    begin
      if (stop_take)
        stop_flag_q <= 1'b1;
      else if (wr_acc && paddr == REG_MODE1)
        stop_flag_q <= pwdata[BIT_STOP_FLAG];
      if (wait_take)
        wait_flag_q <= 1'b1;
      else if (wr_acc && paddr == REG_MODE1)
        wait_flag_q <= pwdata[BIT_WAIT_FLAG];
    end
  end

  // Mode sequencing
  assign stop_take = (state_q == ST_RUN) && stop_instruction &&
                     !stop_dis_q;
  assign wait_take = (state_q == ST_RUN) && !stop_take &&
                     wait_instruction;
  assign timed_wake = !ext_clk_q || sys_sel_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (stop_take)
          state_d = ST_STOP;
        else if (wait_take)
          state_d = ST_WAIT;
      ST_STOP:
        if (wake_irq)
          state_d = timed_wake ? ST_WAKE : ST_RUN;
      ST_WAKE:
        if (wdt_expire)
          state_d = ST_RUN;
      ST_WAIT:
        if (wake_irq)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  // Hardware reset returns to normal running state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // Oscillator divider; idle while the oscillator is stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= '0;
    else if (osc_en)
      pre_q <= pre_q + PRE_W'(1);
  end

  always_comb
  begin
    case (wake_src_q)
      SRC_DIV32:
        wake_tick = &pre_q[DIV_32-1:0];
      SRC_DIV16:
        wake_tick = &pre_q[DIV_16-1:0];
      SRC_DIV128:
        wake_tick = &pre_q[DIV_128-1:0];
      SRC_DIV64:
        wake_tick = &pre_q[DIV_64-1:0];
      default:
        wake_tick = 1'b0;
    endcase
  end

  // Run source stays as before stop, since the select is untouched
  assign run_tick = freq_sel_q ? &pre_q[DIV_32-1:0]
                               : &pre_q[DIV_512-1:0];
  assign wdt_tick = (state_q == ST_RUN) ? run_tick :
                    (state_q == ST_WAKE) ? wake_tick : 1'b0;
  assign wdt_load = restart_wr || stop_take ||
                    (state_q == ST_STOP && wake_irq) ||
                    (state_q == ST_WAKE && wdt_expire) ||
                    (state_q == ST_RUN && wdt_expire);

  wdt_counter u_wdt (
    .pclk(pclk),
    .presetn(presetn),
    .load(wdt_load),
    .tick(wdt_tick),
    .count_q(wdt_count),
    .expire(wdt_expire)
  );

  // Expiry during timed wake raises no watchdog request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_irq <= 1'b0;
    else
      wdt_irq <= wdt_expire && (state_q == ST_RUN) &&
                 !restart_wr && !stop_take;
  end

  // Clock gating and peripheral limits
  assign slow_clk_off = (state_q == ST_STOP) || (state_q == ST_WAKE) ||
                        (state_q == ST_WAIT && sys_stop_q);
  assign osc_en = (state_q != ST_STOP);
  assign pll_run = pll_en_q && (state_q == ST_RUN ||
                                state_q == ST_WAIT);
  assign cpu_clk_en = (state_q == ST_RUN);
  assign bus_interface_clock_en = (state_q == ST_RUN);
  assign watchdog_fast_count_clock_en = (state_q == ST_RUN) &&
                                        freq_sel_q;
  assign watchdog_slow_count_clock_en = (state_q == ST_RUN) &&
                                        !freq_sel_q;
  assign system_clock_signal_en = !slow_clk_off;
  assign divided_peripheral_clocks_en = !slow_clk_off;
  assign timer_event_only = slow_clk_off;
  assign serial_ext_clock_only = slow_clk_off;
  assign converter_run = !slow_clk_off;
  assign pin_hold = (state_q != ST_RUN);

  // Checks
  chk_stop_disabled: assert property
    (state_q == ST_RUN && stop_instruction && stop_dis_q && !wait_instruction
    |=> state_q == ST_RUN && !pin_hold)
    else $error("disabled stop opcode changed mode");

  chk_stop_entry: assert property
    (stop_take |=> state_q == ST_STOP && wdt_count == WDT_FULL && !osc_en)
    else $error("stop entry wrong");

  chk_wait_entry: assert property
    (wait_take |=> state_q == ST_WAIT && osc_en && !cpu_clk_en)
    else $error("wait entry wrong");

  chk_wdt_frozen: assert property
    ((state_q == ST_WAIT || state_q == ST_STOP) && !wake_irq
    |=> $stable(wdt_count))
    else $error("watchdog moved in low-power mode");

  chk_osc_stop: assert property
    (state_q == ST_STOP |-> !osc_en && !pll_run)
    else $error("oscillator running in stop");

  chk_wait_sysclk: assert property
    (state_q == ST_WAIT |-> system_clock_signal_en == !sys_stop_q &&
    converter_run == !sys_stop_q && pll_run == pll_en_q)
    else $error("wait clock gating wrong");

  chk_periph_limit: assert property
    (state_q == ST_STOP |-> timer_event_only && serial_ext_clock_only &&
    !converter_run && pin_hold)
    else $error("peripherals not limited in stop");

  chk_timed_wake: assert property
    (state_q == ST_STOP && wake_irq && timed_wake
    |=> !cpu_clk_en && wdt_count == WDT_FULL ##1 !cpu_clk_en)
    else $error("timed wake resumed too early");

  chk_wake_release: assert property
    (state_q == ST_WAKE && wdt_expire
    |=> cpu_clk_en && wdt_count == WDT_FULL ##1 !wdt_irq)
    else $error("wake release wrong");

  chk_direct_wake: assert property
    (state_q == ST_STOP && wake_irq && !timed_wake
    |=> cpu_clk_en && bus_interface_clock_en)
    else $error("untimed wake not immediate");

  chk_select_write: assert property
    (restart_wr && select_wr && state_q == ST_RUN
    |=> wdt_count == WDT_FULL &&
    freq_sel_q == $past(pwdata[BIT_FREQ_SEL]))
    else $error("two-lane restart lost select byte");

  cov_timed_wake: cover property (state_q == ST_WAKE ##1 state_q == ST_RUN);
  cov_direct_wake: cover property (state_q == ST_STOP ##1 state_q == ST_RUN);
  cov_wait_wake: cover property (state_q == ST_WAIT ##1 state_q == ST_RUN);
endmodule

// ### hdl/wdt_counter.sv
// Twelve-bit watchdog down-counter with reload and top-bit expiry
`timescale 1ns/10ps
module wdt_counter
  import lpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic tick,
  output logic [lpm_pkg::WDT_W-1:0] count_q,
  output logic expire
);
  import lpm_pkg::*;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= WDT_FULL;
    else if (load)
      count_q <= WDT_FULL;
    else if (tick)
      count_q <= count_q - WDT_W'(1);
  end

  // Top bit clears on this tick; load left out so the parent has no loop
  assign expire = tick && (count_q == WDT_MSB_LAST);
endmodule

// ### include/lpm_pkg.sv
// Constants, register map and types for the low-power mode controller
package lpm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WDT_W = 12;
  localparam int PRE_W = 9;

  localparam logic [ADDR_W-1:0] REG_WDT = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MODE0 = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MODE1 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CLK = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;

  // REG_WDT: lane 0 restarts, lane 1 holds the count source selects
  localparam int STRB_RESTART = 0;
  localparam int STRB_SELECT = 1;
  localparam int BIT_FREQ_SEL = 8;
  localparam int BIT_WAKE_SRC_LO = 14;
  localparam int BIT_WAKE_SRC_HI = 15;
  // REG_MODE0
  localparam int BIT_STOP_DIS = 0;
  localparam int BIT_EXT_CLK = 1;
  // REG_MODE1
  localparam int BIT_STOP_FLAG = 0;
  localparam int BIT_WAIT_FLAG = 1;
  localparam int BIT_SYS_STOP = 3;
  // REG_CLK
  localparam int BIT_PLL_EN = 1;
  localparam int BIT_SYS_SEL = 5;
  // REG_STAT
  localparam int BIT_STATE_LO = 16;

  localparam logic [WDT_W-1:0] WDT_FULL = 12'hfff;
  localparam logic [WDT_W-1:0] WDT_MSB_LAST = 12'h800;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Divider taps, as log2 of the oscillator division
  localparam int DIV_16 = 4;
  localparam int DIV_32 = 5;
  localparam int DIV_64 = 6;
  localparam int DIV_128 = 7;
  localparam int DIV_512 = 9;

  typedef enum logic [1:0] {
    SRC_DIV32,
    SRC_DIV16,
    SRC_DIV128,
    SRC_DIV64
  } wake_src_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP,
    ST_WAKE,
    ST_WAIT
  } lpm_state_t;
endpackage

// ### testbench/core_model.sv
// Processor core stand-in issuing mode instructions and wake requests
`timescale 1ns/10ps
module core_model
(
  input wire logic pclk,
  output logic stop_instruction,
  output logic wait_instruction,
  output logic wake_irq
);
  initial
  begin
    stop_instruction = 1'b0;
    wait_instruction = 1'b0;
    wake_irq = 1'b0;
  end

  // Issued even with stop disabled, as runaway code would
  task automatic exec_stop();
    @(posedge pclk);
    stop_instruction <= 1'b1;
    @(posedge pclk);
    stop_instruction <= 1'b0;
  endtask

  task automatic exec_wait();
    @(posedge pclk);
    wait_instruction <= 1'b1;
    @(posedge pclk);
    wait_instruction <= 1'b0;
  endtask

  task automatic raise_wake();
    @(posedge pclk);
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
  endtask
endmodule

// ### testbench/low_power_mode_control_tb_top.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module low_power_mode_control_tb_top;
  import lpm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat, d;
  logic [3:0] pstrb;
  logic stop_instruction, wait_instruction, wake_irq, wdt_irq;
  logic osc_en, pll_run, cpu_clk_en, bus_interface_clock_en;
  logic watchdog_fast_count_clock_en, watchdog_slow_count_clock_en;
  logic system_clock_signal_en, divided_peripheral_clocks_en;
  logic timer_event_only, serial_ext_clock_only, converter_run, pin_hold;
  logic ss, pe, fs;
  logic [1:0] src;
  logic [11:0] gate;
  int n_fail, checks, cyc, t0, irqs, dv;

  assign gate = {osc_en, pll_run, cpu_clk_en, bus_interface_clock_en,
    watchdog_fast_count_clock_en, watchdog_slow_count_clock_en,
    system_clock_signal_en, divided_peripheral_clocks_en, converter_run,
    timer_event_only, serial_ext_clock_only, pin_hold};

  low_power_mode_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_instruction(stop_instruction),
    .wait_instruction(wait_instruction), .wake_irq(wake_irq),
    .osc_en(osc_en), .pll_run(pll_run), .cpu_clk_en(cpu_clk_en),
    .bus_interface_clock_en(bus_interface_clock_en),
    .watchdog_fast_count_clock_en(watchdog_fast_count_clock_en),
    .watchdog_slow_count_clock_en(watchdog_slow_count_clock_en),
    .system_clock_signal_en(system_clock_signal_en),
    .divided_peripheral_clocks_en(divided_peripheral_clocks_en),
    .timer_event_only(timer_event_only),
    .serial_ext_clock_only(serial_ext_clock_only),
    .converter_run(converter_run), .pin_hold(pin_hold),
    .wdt_irq(wdt_irq));

  core_model core (.pclk(pclk), .stop_instruction(stop_instruction),
    .wait_instruction(wait_instruction), .wake_irq(wake_irq));

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [11:0] exp_gate(input lpm_state_t st);
    logic run, lo;
    run = (st == ST_RUN);
    lo = (st == ST_STOP) || (st == ST_WAKE) || ((st == ST_WAIT) && ss);
    return {st != ST_STOP, pe & (run | (st == ST_WAIT)), run, run,
      run & fs, run & ~fs, ~lo, ~lo, ~lo, lo, lo, ~run};
  endfunction

  function automatic int wake_div(input logic [1:0] s);
    case (s)
      2'b00: return 32;
      2'b01: return 16;
      2'b10: return 128;
      default: return 64;
    endcase
  endfunction

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] ex);
    checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, ex);
    end
  endtask

  task automatic check_range(input logic [31:0] got, input int lo, hi);
    checks++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      n_fail++;
      $display("mismatch at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic check_gate(input lpm_state_t st);
    #1;
    check_word({20'h0, gate}, {20'h0, exp_gate(st)});
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    forever
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counter reading expected after t0, two ticks of slack below and one tick above
  task automatic check_count(input int div);
    apb(1'b0, REG_STAT, DATA_ZERO, 4'h0);
    check_range(rdat[11:0], 4095 - (cyc - t0) / div - 2,
      4095 - (cyc - t0) / div + 1);
  endtask

  task automatic hw_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ss = 1'b0;
    pe = 1'b0;
    fs = 1'b0;
  endtask

  initial
  begin
    #600_000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = DATA_ZERO;
    pstrb = 4'h0;
    cyc = 0;
    void'($urandom(86));
    hw_reset();
    check_gate(ST_RUN);
    apb(1'b0, 8'h14, DATA_ZERO, 4'h0);
    check_word({31'h0, rerr}, 32'h0000_0001);
    d = $urandom & ~32'h0000_0020;
    pe = d[BIT_PLL_EN];
    apb(1'b1, REG_CLK, d, 4'hf);
    apb(1'b0, REG_CLK, DATA_ZERO, 4'h0);
    check_word(rdat, d & 32'h0000_0002);
    src = 2'($urandom);
    fs = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      // Second pass rewrites the live selects, with the same two-lane restart write
      apb(1'b1, REG_WDT, {16'h0, src, 5'h00, 1'b1, 8'h00}, 4'b0011);
      t0 = cyc;
      repeat (300 + $urandom % 64) @(posedge pclk);
      check_count(32);
    end
    for (int i = 0; i < 2; i++)
    begin
      ss = i[0];
      apb(1'b1, REG_MODE1, 32'(ss) << BIT_SYS_STOP, 4'hf);
      core.exec_wait();
      check_gate(ST_WAIT);
      apb(1'b0, REG_STAT, DATA_ZERO, 4'h0);
      d = rdat;
      check_word({30'h0, d[17:16]}, 32'h0000_0003);
      repeat (50 + $urandom % 100) @(posedge pclk);
      apb(1'b0, REG_STAT, DATA_ZERO, 4'h0);
      check_word(rdat, d);
      core.raise_wake();
      check_gate(ST_RUN);
    end
    apb(1'b1, REG_MODE0, 32'h0000_0001, 4'hf);
    core.exec_stop();
    check_gate(ST_RUN);
    apb(1'b1, REG_MODE0, 32'h0000_0002, 4'hf);
    core.exec_stop();
    check_gate(ST_STOP);
    apb(1'b0, REG_STAT, DATA_ZERO, 4'h0);
    check_word(rdat & 32'h0003_0fff, 32'h0001_0fff);
    repeat (200) @(posedge pclk);
    apb(1'b0, REG_STAT, DATA_ZERO, 4'h0);
    check_word(rdat & 32'h0003_0fff, 32'h0001_0fff);
    core.raise_wake();
    check_gate(ST_RUN);
    hw_reset();
    for (int s = 0; s < 4; s++)
    begin
      src = s[1:0];
      fs = 1'b1;
      apb(1'b1, REG_WDT, {16'h0, src, 5'h00, 1'b1, 8'h00}, 4'b0011);
      core.exec_stop();
      core.raise_wake();
      t0 = cyc;
      check_gate(ST_WAKE);
      repeat (1024) @(posedge pclk);
      dv = wake_div(src);
      check_count(dv);
      check_word({30'h0, rdat[17:16]}, 32'h0000_0002);
      hw_reset();
      check_gate(ST_RUN);
    end
    fs = 1'b1;
    apb(1'b1, REG_WDT, 32'h0000_4100, 4'b0011);
    core.exec_stop();
    core.raise_wake();
    t0 = cyc;
    irqs = 0;
    while (cpu_clk_en !== 1'b1 && cyc - t0 < 40000)
    begin
      @(posedge pclk);
      if (wdt_irq === 1'b1)
        irqs++;
    end
    check_range(cyc - t0, 2047 * 16, 2049 * 16 + 2);
    check_word(irqs, 0);
    check_gate(ST_RUN);
    t0 = cyc;
    check_count(32);
    tally_and_finish();
  end
endmodule
